// File: logic/dpr_top.sv
// Drive power-up sequencing, recalibration, stepping and select gating
`timescale 1ns/1ps
`include "dpr_map.svh"
// How it works
// - Count 512 full disc revolutions after spin-up before recalibrating.
// - Recalibration advances only while host step input is inactive.
// - Status comes true in order: track zero, seek done, ready.
// - Read, write and seek requests are ignored until ready.
// - Step pulses, read and write requests are honoured only while own select line is asserted; direction passes through regardless.
// - Status outputs drive the shared cable only while selected.
// - One counted revolution per spindle turn at nominal 3600 rpm.
// - Each step pulse moves heads one track; low direction inward.
module dpr_top
   import dpr_pkg::*;
(
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic spindle_pulse,
   input  wire logic trk0_sensor,
   input  wire logic select_n,
   input  wire logic step_n,
   input  wire logic dir_in_n,
   input  wire logic wr_gate,
   input  wire logic rd_req,
   output logic      motor_step,
   output logic      motor_out,
   output logic      wr_enable,
   output logic      rd_enable,
   output logic      sel_active_n,
   output logic      trk0_o,
   output logic      trk0_oe_n,
   output logic      seek_done_o,
   output logic      seek_done_oe_n,
   output logic      ready_o,
   output logic      ready_oe_n
);
   //-----------------------------------------
   // Pin synchronisers
   //-----------------------------------------
   logic [6:0] pins_s;
   // Active-low select and step pins inverted first so reset reads them inactive
   dpr_sync #(.W(7)) u_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    ({spindle_pulse, trk0_sensor, ~select_n, ~step_n, dir_in_n, wr_gate, rd_req}),
      .q    (pins_s)
   );
   logic spin_s, trk0_s, sel_s, step_s, dir_out_s, wg_s, rd_s;
   assign spin_s    = pins_s[6];
   assign trk0_s    = pins_s[5];
   assign sel_s     = pins_s[4];
   assign step_s    = pins_s[3];
   assign dir_out_s = pins_s[2];
   assign wg_s      = pins_s[1];
   assign rd_s      = pins_s[0];

   //-----------------------------------------
   // Revolution counting
   //-----------------------------------------
   dpr_state_e             state_q;
   logic                   spin_d1_q;
   logic                   rev_tick;
   logic [`DPR_REV_W-1:0]  rev_cnt_q;
   logic [`DPR_STEP_W-1:0] stp_cnt_q;
   logic                   step_d1_q;
   logic                   host_step;
   logic                   ready;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         spin_d1_q <= 1'b0;
      else
         spin_d1_q <= spin_s;
   end
   assign rev_tick = spin_s & ~spin_d1_q;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         rev_cnt_q <= '0;
      else if (state_q == DPR_SPINUP && rev_tick)
         rev_cnt_q <= rev_cnt_q + 1'b1;
   end

   //-----------------------------------------
   // Recalibration pacing
   //-----------------------------------------
   // Held step input freezes the pacing count
   always_ff @(posedge clk)
   begin
      if (!nrst)
         stp_cnt_q <= '0;
      else if (state_q != DPR_RECAL || stp_cnt_q == `DPR_STEP_W'(`DPR_STEP_CYC - 1))
         stp_cnt_q <= '0;
      else if (!step_s)
         stp_cnt_q <= stp_cnt_q + 1'b1;
   end

   //-----------------------------------------
   // Sequencer
   //-----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
         state_q <= DPR_SPINUP;
      else
      begin
         unique case (state_q)
            DPR_SPINUP:
               if (rev_tick && rev_cnt_q == `DPR_REV_W'(`DPR_REVS_BEFORE_CAL - 1))
                  state_q <= DPR_RECAL;
            DPR_RECAL:
               if (trk0_s && !step_s)
                  state_q <= DPR_TRK0;
            DPR_TRK0:
               state_q <= DPR_SKDONE;
            DPR_SKDONE:
               state_q <= DPR_READY;
            DPR_READY:
               state_q <= DPR_READY;
            default:
               state_q <= DPR_SPINUP;
         endcase
      end
   end
   assign ready = (state_q == DPR_READY);

   //-----------------------------------------
   // Head motion
   //-----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
         step_d1_q <= 1'b0;
      else
         step_d1_q <= step_s;
   end
   // Leading edge of one selected step pulse only
   assign host_step = step_s & ~step_d1_q & sel_s & ready;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         motor_step <= 1'b0;
         motor_out  <= 1'b0;
      end
      else if (state_q == DPR_RECAL)
      begin
         motor_step <= !step_s && !trk0_s && stp_cnt_q == `DPR_STEP_W'(`DPR_STEP_CYC - 1);
         motor_out  <= 1'b1;
      end
      else
      begin
         motor_step <= host_step;
         motor_out  <= dir_out_s;
      end
   end

   //-----------------------------------------
   // Data path gating
   //-----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         wr_enable <= 1'b0;
         rd_enable <= 1'b0;
      end
      else
      begin
         wr_enable <= wg_s & sel_s & ready;
         rd_enable <= rd_s & ~wg_s & sel_s & ready;
      end
   end

   //-----------------------------------------
   // Status outputs, open-drain style
   //-----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         trk0_o      <= 1'b0;
         seek_done_o <= 1'b0;
         ready_o     <= 1'b0;
      end
      else
      begin
         trk0_o      <= state_q >= DPR_TRK0 ? trk0_s : 1'b0;
         seek_done_o <= state_q >= DPR_SKDONE;
         ready_o     <= ready;
      end
   end

   //-----------------------------------------
   // Cable drive enables, low while selected
   //-----------------------------------------
   // Deselected drive leaves the shared lines to other drives
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         trk0_oe_n      <= 1'b1;
         seek_done_oe_n <= 1'b1;
         ready_oe_n     <= 1'b1;
         sel_active_n   <= 1'b1;
      end
      else
      begin
         trk0_oe_n      <= ~sel_s;
         seek_done_oe_n <= ~sel_s;
         ready_oe_n     <= ~sel_s;
         sel_active_n   <= ~sel_s;
      end
   end
endmodule // dpr_top

// File: logic/dpr_map.svh
// Constants for the power-up recalibrate and select block
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH
`define DPR_CLK_HZ          200000000
`define DPR_SPIN_RPM        3600
`define DPR_REV_CYC         (`DPR_CLK_HZ / `DPR_SPIN_RPM * 60)
`define DPR_REVS_BEFORE_CAL 512
`define DPR_REV_W           10
`define DPR_STEP_PERIOD_NS  3000000
`define DPR_STEP_CYC        ((`DPR_STEP_PERIOD_NS * 64'd200) / 64'd1000)
`define DPR_STEP_W          20
`define DPR_TRACK_W         10
`endif

// File: logic/dpr_pkg.sv
// Types for the power-up recalibrate and select block
package dpr_pkg;
   typedef enum logic [2:0] {
      DPR_SPINUP  = 3'h0,
      DPR_RECAL   = 3'h1,
      DPR_TRK0    = 3'h2,
      DPR_SKDONE  = 3'h3,
      DPR_READY   = 3'h4
   } dpr_state_e;
endpackage

// File: logic/dpr_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module dpr_sync #(parameter int W = 1)
(
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         q      <= '0;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule // dpr_sync

// File: tb/dpr_chk_assertions.sv
// Checker for power-up order, step gating and select gating
`timescale 1ns/1ps
module dpr_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic select_n,
   input wire logic step_n,
   input wire logic motor_step,
   input wire logic motor_out,
   input wire logic rd_enable,
   input wire logic trk0_o,
   input wire logic seek_done_o,
   input wire logic ready_o,
   input wire logic ready_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_ORDER: assert property ($rose(trk0_o) && !seek_done_o |=> $rose(seek_done_o) ##1 $rose(ready_o))
      else $error("order");
   AST_READY: assert property ($rose(ready_o) |-> $past(seek_done_o)) else $error("ready");
   AST_REQ: assert property (rd_enable |-> ready_o || $past(ready_o)) else $error("read");
   AST_PULSE: assert property (motor_step |=> !motor_step) else $error("pulse");
   AST_HOST: assert property (motor_step && ready_o |-> !$past(step_n, 3) && $past(step_n, 4) && !$past(select_n, 3))
      else $error("step");
   AST_OUT: assert property (motor_step && !ready_o |-> motor_out) else $error("dir");
   AST_QUIET: assert property (motor_step && !ready_o |-> $past(step_n, 3)) else $error("quiet");
   AST_OE: assert property (select_n [*5] |-> ready_oe_n) else $error("oe");
   cover property ($rose(ready_o));
   cover property (motor_step && ready_o);
   cover property ($rose(ready_oe_n));
endmodule // dpr_chk
bind dpr_top dpr_chk chk_u (.clk(clk), .nrst(nrst), .select_n(select_n), .step_n(step_n),
   .motor_step(motor_step), .motor_out(motor_out), .rd_enable(rd_enable), .trk0_o(trk0_o),
   .seek_done_o(seek_done_o), .ready_o(ready_o), .ready_oe_n(ready_oe_n));

// File: tb/dpr_mech.sv
// Spindle and head carriage model
`timescale 1ns/1ps
module dpr_mech (
   input  wire logic clk,
   input  wire logic motor_step,
   input  wire logic motor_out,
   output logic      spindle_pulse,
   output logic      trk0_sensor
);
   logic [3:0] rev_q = 4'h0;
   logic [9:0] pos_q = 10'h000;
   // Spindle turns freely, one pulse per turn
   always_ff @(posedge clk) rev_q <= rev_q + 4'h1;
   assign spindle_pulse = rev_q[3];
   // One track per step, outward stops at zero
   always_ff @(posedge clk)
      if (motor_step)
         pos_q <= motor_out ? pos_q - 10'(pos_q != 10'h000) : pos_q + 10'h001;
   assign trk0_sensor = (pos_q == 10'h000);
endmodule // dpr_mech

// File: tb/dpr_top_tb.sv
// Bench for power-up sequencing, stepping and select gating
`timescale 1ns/1ps
module dpr_top_tb;
   logic clk = 0, nrst = 0, select_n = 0, step_n = 1, dir_in_n = 1, wr_gate = 1, rd_req = 1;
   logic spindle_pulse, trk0_sensor, motor_step, motor_out, wr_enable, rd_enable, sel_active_n;
   logic trk0_o, trk0_oe_n, seek_done_o, seek_done_oe_n, ready_o, ready_oe_n;
   int   miscompares = 0, tests_run = 0;
   int   track = 0;
   always #2.5 clk = ~clk;
   dpr_top dut_u (.clk(clk), .nrst(nrst), .spindle_pulse(spindle_pulse), .trk0_sensor(trk0_sensor),
      .select_n(select_n), .step_n(step_n), .dir_in_n(dir_in_n), .wr_gate(wr_gate), .rd_req(rd_req),
      .motor_step(motor_step), .motor_out(motor_out), .wr_enable(wr_enable), .rd_enable(rd_enable),
      .sel_active_n(sel_active_n), .trk0_o(trk0_o), .trk0_oe_n(trk0_oe_n), .seek_done_o(seek_done_o),
      .seek_done_oe_n(seek_done_oe_n), .ready_o(ready_o), .ready_oe_n(ready_oe_n));
   dpr_mech mech_u (.clk(clk), .motor_step(motor_step), .motor_out(motor_out),
      .spindle_pulse(spindle_pulse), .trk0_sensor(trk0_sensor));
   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1)
      begin
         $display("unexpected %0t %s", $time, msg);
         miscompares++;
      end
   endtask
   task automatic conclude;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic t_powerup;
      for (int n = 1; n <= 512; n++)
         @(posedge spindle_pulse);
      @(negedge clk);
      chk(!ready_o && !rd_enable && !wr_enable, "early");
      for (int i = 0; i < 40 && ready_o !== 1'b1; i++)
         @(negedge clk);
      repeat (4) @(negedge clk);
      chk(ready_o && trk0_o && seek_done_o && !ready_oe_n, "ready");
      chk(wr_enable && !rd_enable, "write gate");
   endtask
   task automatic t_read;
      wr_gate = 0;
      repeat (4) @(negedge clk);
      chk(rd_enable && !wr_enable, "read");
   endtask
   task automatic t_step(input logic dir);
      int hit;
      hit = 0;
      @(negedge clk);
      dir_in_n = dir;
      @(negedge clk);
      step_n = 0;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge clk);
         if (i == 2)
            step_n = 1;
         if (motor_step === 1'b1 && motor_out === dir)
            hit++;
      end
      if (!select_n)
         track = dir ? track - 1 : track + 1;
      chk(hit == (select_n ? 0 : 1), "step");
      chk(trk0_o == (track == 0), "track");
   endtask
   task automatic t_desel;
      select_n = 1;
      repeat (5) @(negedge clk);
      chk(ready_oe_n && trk0_oe_n && seek_done_oe_n && sel_active_n && !rd_enable, "desel");
      t_step(1'b0);
      select_n = 0;
      repeat (5) @(negedge clk);
      chk(!ready_oe_n && !trk0_oe_n && !seek_done_oe_n && !sel_active_n, "sel");
   endtask
   initial
   begin
      repeat (3) @(negedge clk);
      chk(ready_oe_n && trk0_oe_n && sel_active_n && !ready_o, "reset");
      nrst = 1;
      t_powerup();
      t_read();
      t_step(1'b0);
      t_step(1'b1);
      t_desel();
      conclude();
   end
   // Watchdog: 512 turns of 16 cycles plus margin
   initial
   begin
      #60us;
      miscompares++;
      conclude();
   end
endmodule // dpr_top_tb
